// >>> hw/light_ctrl_pkg.sv
// Purpose: Shared constants for the step-down and brightness-range controller.
// Assumes: 40 MHz system clock, Wishbone register access, lux as 12-bit ints.
// Notes: Percent figures are integer percent; byte outputs use 0..255 scale.
//
// Overview of operation
// [R1] With lower-limit evaluation off, hold output at the lower limit.
// [R2] Step-down start: switch off, send minimum, or send 1..100 percent.
// [R3] Minimum output is value telegram 1 or dimming step 100 percent down.
// [R4] Dimming step-down starts a wait of 10 s plus configured extra time.
// [R5] After the wait, switch off in chosen format or keep output constant.
// [R6] Ignore mode: finish step-down, then restart startup if presence stays.
// [R7] React mode: new presence aborts step-down and enters startup at once.
// [R8] Configured-output option needs new hardware, else acts as minimum.
// [R9] Maximum illuminance scales output steps and adaptive startup value.
// [R10] Below lower brightness threshold, shorten telegram interval.
// [R11] Standard mode: maximum lux is setpoint times 1.2, threshold 0 lux.
// [R12] User mode: maximum illuminance 10..2000 lux, threshold 0..2000 lux.
// [R13] Configurer keeps threshold below setpoint and setpoint below maximum; user-mode registers are clamped only to their own ranges.
// [R14] Setpoint range: standard 20..1000 in 50 lux steps, user 10..2000.
// [R15] Switch-off brightness is recomputed whenever the setpoint shifts.
// [R16] Switch-off lux is setpoint plus setpoint times both hystereses.
// [R17] All timers run from one-second tick and clear on reset.
package light_ctrl_pkg;

  // ****************************************************************
  // Register byte offsets.
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SETPOINT = 8'h04;
  localparam logic [7:0] REG_RANGE = 8'h08;
  localparam logic [7:0] REG_STEP = 8'h0c;
  localparam logic [7:0] REG_EVENT = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_DERIVED = 8'h18;

  // ****************************************************************
  // Control register field positions.
  // ****************************************************************
  localparam int CTL_USER_MODE = 0;
  localparam int CTL_LIMIT_EVAL = 1;
  localparam int CTL_BEGIN_LO = 2;
  localparam int CTL_MIN_REL = 4;
  localparam int CTL_AFTER_KEEP = 5;
  localparam int CTL_OFF_REL = 6;
  localparam int CTL_PRES_REACT = 7;
  localparam int CTL_NEW_HW = 8;
  localparam int CTL_HYST_LO = 16;
  localparam int CTL_ADDH_LO = 24;

  // ****************************************************************
  // Event register bits, write one to trigger.
  // ****************************************************************
  localparam int EVT_PRESENCE = 0;
  localparam int EVT_STEP_DOWN = 1;
  localparam int EVT_AT_LIMIT = 2;

  // ****************************************************************
  // Reset values and ranges.
  // ****************************************************************
  localparam logic [31:0] CTRL_RESET = 32'h0a0a_0000;
  localparam logic [11:0] SETPOINT_RESET = 12'h12c;
  localparam logic [11:0] USER_MAX_RESET = 12'h168;
  localparam logic [11:0] USER_THR_RESET = 12'h000;
  localparam logic [6:0] CFG_PCT_RESET = 7'h32;
  localparam logic [7:0] ADD_WAIT_RESET = 8'h00;
  localparam logic [7:0] PACE_NORM_RESET = 8'h05;
  localparam logic [7:0] PACE_FAST_RESET = 8'h02;
  localparam logic [11:0] LUX_MAX = 12'h7d0;
  localparam logic [11:0] USER_MAX_MIN = 12'h00a;
  localparam logic [11:0] STD_SP_MIN = 12'h014;
  localparam logic [11:0] STD_SP_MAX = 12'h3e8;
  localparam logic [11:0] STD_SP_STEP = 12'h032;
  localparam logic [11:0] USER_SP_MIN = 12'h00a;
  localparam logic [7:0] OUT_MIN_VALUE = 8'h01;
  localparam logic [7:0] OUT_OFF_VALUE = 8'h00;
  localparam logic [3:0] DIM_DOWN_100 = 4'h1;
  localparam logic [6:0] PCT_MIN = 7'h01;
  localparam logic [6:0] PCT_MAX = 7'h64;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLK_HZ = 40_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = CLK_HZ * TICK_PERIOD_S;
  localparam logic [7:0] WAIT_BASE_S = 8'h0a;

  // ****************************************************************
  // Choice at the beginning of the step-down phase.
  // ****************************************************************
  typedef enum logic [1:0] {
    BEGIN_OFF = 2'b00,
    BEGIN_MIN = 2'b01,
    BEGIN_CFG = 2'b10
  } begin_sel_t;

  // ****************************************************************
  // Controller phases.
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_STARTUP = 3'b001,
    ST_MAIN = 3'b010,
    ST_HOLD = 3'b011,
    ST_SD_WAIT = 3'b100,
    ST_SD_END = 3'b101
  } phase_t;

  // ****************************************************************
  // Telegram kinds on the output port.
  // ****************************************************************
  localparam logic [1:0] TG_SWITCH = 2'b00;
  localparam logic [1:0] TG_VALUE = 2'b01;
  localparam logic [1:0] TG_DIM = 2'b10;

endpackage

// >>> hw/light_ctrl.sv
// Purpose: Step-down phase, lower-limit handling and brightness-range math.
// Assumes: Wishbone classic slave, 32-bit data, single 40 MHz clock.
// Notes: Startup and main control phases live elsewhere; this block flags
//   them and supplies their range parameters and telegram pacing.
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
module light_ctrl #(
  parameter int TICK_CYC = light_ctrl_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Wishbone slave.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Sensing.
  input wire logic [11:0] i_lux,
  input wire logic i_presence,
  // Telegram port toward the actuators.
  output logic o_tg_valid,
  output logic [1:0] o_tg_kind,
  output logic [7:0] o_tg_data,
  // Phase hand-off to the startup controller.
  output logic o_startup_req,
  output logic o_fast_pace
);
  import light_ctrl_pkg::*;

  logic [31:0] ctrl;
  logic [11:0] setpoint_raw;
  logic [11:0] user_max;
  logic [11:0] user_thr;
  logic [6:0] cfg_pct;
  logic [7:0] add_wait;
  logic [7:0] pace_norm;
  logic [7:0] pace_fast;
  logic [11:0] setpoint;
  logic [11:0] max_lux;
  logic [11:0] thr_lux;
  logic [12:0] off_lux;
  logic [7:0] step_gain;
  logic [7:0] adapt_out;
  logic [25:0] tick_cnt;
  logic tick;
  logic [8:0] wait_cnt;
  logic [7:0] pace_cnt;
  logic [7:0] out_level;
  phase_t phase;
  logic pres_q;
  logic pres_seen;
  logic ev_pres;
  logic ev_sd;
  logic ev_limit;
  logic wr;
  begin_sel_t begin_sel;

  // ****************************************************************
  // Wishbone register access.
  // ****************************************************************

  // Single-cycle acknowledge; ack drops the cycle after it was given.
  assign wr = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack;
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
    end else begin
      o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
    end
  end

  // Configuration writes, honouring byte lanes per register word.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ctrl <= CTRL_RESET;
      setpoint_raw <= SETPOINT_RESET;
      user_max <= USER_MAX_RESET;
      user_thr <= USER_THR_RESET;
      cfg_pct <= CFG_PCT_RESET;
      add_wait <= ADD_WAIT_RESET;
      pace_norm <= PACE_NORM_RESET;
      pace_fast <= PACE_FAST_RESET;
    end else if (wr) begin
      case (i_wb_adr)
        REG_CTRL: begin
          for (int b = 0; b < 4; b++) begin
            if (i_wb_sel[b]) begin
              ctrl[b*8 +: 8] <= i_wb_dat[b*8 +: 8];
            end
          end
        end
        REG_SETPOINT: begin
          if (i_wb_sel[1:0] == 2'b11) begin
            setpoint_raw <= i_wb_dat[11:0];
          end
          if (i_wb_sel[3:2] == 2'b11) begin
            cfg_pct <= i_wb_dat[22:16];
          end
        end
        REG_RANGE: begin
          if (i_wb_sel[1:0] == 2'b11) begin
            user_max <= i_wb_dat[11:0];
          end
          if (i_wb_sel[3:2] == 2'b11) begin
            user_thr <= i_wb_dat[27:16];
          end
        end
        REG_STEP: begin
          if (i_wb_sel[0]) begin
            add_wait <= i_wb_dat[7:0];
          end
          if (i_wb_sel[1]) begin
            pace_norm <= i_wb_dat[15:8];
          end
          if (i_wb_sel[2]) begin
            pace_fast <= i_wb_dat[23:16];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Event strobes, one cycle each, from writes to the event register.
  assign ev_pres = wr && i_wb_adr == REG_EVENT && i_wb_sel[0] &&
                   i_wb_dat[EVT_PRESENCE];
  assign ev_sd = wr && i_wb_adr == REG_EVENT && i_wb_sel[0] &&
                 i_wb_dat[EVT_STEP_DOWN];
  assign ev_limit = wr && i_wb_adr == REG_EVENT && i_wb_sel[0] &&
                    i_wb_dat[EVT_AT_LIMIT];

  // Read mux; unmapped addresses read as zero and still acknowledge.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_wb_dat <= 32'h0000_0000;
    end else begin
      case (i_wb_adr)
        REG_CTRL: o_wb_dat <= ctrl;
        REG_SETPOINT: o_wb_dat <= {9'h000, cfg_pct, 4'h0, setpoint};
        REG_RANGE: o_wb_dat <= {4'h0, thr_lux, 4'h0, max_lux};
        REG_STEP: o_wb_dat <= {8'h00, pace_fast, pace_norm, add_wait};
        REG_STATUS: o_wb_dat <= {3'h0, pace_cnt, wait_cnt, out_level,
                                 pres_seen, phase};
        REG_DERIVED: o_wb_dat <= {3'h0, off_lux, adapt_out, step_gain};
        default: o_wb_dat <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // Brightness range and setpoint derivation.
  // ****************************************************************

  // Setpoint clamped per mode; standard mode snaps to 50 lux steps.
  always_comb begin
    logic [11:0] q;
    q = 12'(setpoint_raw / STD_SP_STEP);
    if (ctrl[CTL_USER_MODE]) begin
      if (setpoint_raw < USER_SP_MIN) begin
        setpoint = USER_SP_MIN; // R14
      end else if (setpoint_raw > LUX_MAX) begin
        setpoint = LUX_MAX; // R14
      end else begin
        setpoint = setpoint_raw;
      end
    end else if (setpoint_raw < STD_SP_STEP) begin
      setpoint = STD_SP_MIN; // R14
    end else if (setpoint_raw > STD_SP_MAX) begin
      setpoint = STD_SP_MAX; // R14
    end else begin
      setpoint = 12'(q * STD_SP_STEP); // R14
    end
  end

  // Maximum illuminance and lower threshold per dynamic mode.
  always_comb begin
    if (ctrl[CTL_USER_MODE]) begin
      max_lux = (user_max < USER_MAX_MIN) ? USER_MAX_MIN :
                (user_max > LUX_MAX) ? LUX_MAX : user_max; // R12
      thr_lux = (user_thr > LUX_MAX) ? LUX_MAX : user_thr; // R12
    end else begin
      max_lux = 12'((13'(setpoint) * 13'd6) / 13'd5); // R11
      thr_lux = 12'h000; // R11
    end
  end

  // Switch-off brightness follows the live setpoint, so shifts rescale it.
  assign off_lux = 13'(setpoint) + 13'((22'(setpoint) *
    (22'(ctrl[CTL_HYST_LO +: 8]) + 22'(ctrl[CTL_ADDH_LO +: 8]))) /
    22'd100); // R15 R16

  // Step gain grows with error relative to the maximum illuminance.
  always_comb begin
    logic [11:0] err;
    logic [19:0] gain;
    logic [19:0] adapt;
    err = (i_lux > setpoint) ? i_lux - setpoint : setpoint - i_lux;
    gain = (20'(err) * 20'd255) / 20'(max_lux);
    adapt = (i_lux >= setpoint) ? 20'h0_0000 :
      (20'(setpoint - i_lux) * 20'd255) / 20'(max_lux);
    // Saturate, since a wrapped byte would shrink the step far from target.
    step_gain = (gain > 20'h0_00ff) ? 8'hff : gain[7:0]; // R9
    adapt_out = (adapt > 20'h0_00ff) ? 8'hff : adapt[7:0]; // R9
  end

  // ****************************************************************
  // One-second tick and telegram pacing.
  // ****************************************************************
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt <= 26'h000_0000; // R17
      tick <= 1'b0;
    end else if (tick_cnt == 26'(TICK_CYC - 1)) begin
      tick_cnt <= 26'h000_0000; // R17
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 26'h000_0001;
      tick <= 1'b0;
    end
  end

  // Pace strobe: short interval while the room is darker than threshold.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pace_cnt <= 8'h00; // R17
      o_fast_pace <= 1'b0;
    end else begin
      o_fast_pace <= i_lux < thr_lux; // R10
      if (tick) begin
        if (pace_cnt >= (o_fast_pace ? pace_fast : pace_norm)) begin
          pace_cnt <= 8'h00; // R10
        end else begin
          pace_cnt <= pace_cnt + 8'h01;
        end
      end
    end
  end

  // ****************************************************************
  // Step-down sequencing.
  // ****************************************************************

  // Configured-output choice falls back to minimum on old hardware.
  always_comb begin
    case (ctrl[CTL_BEGIN_LO +: 2])
      2'b00: begin_sel = BEGIN_OFF;
      2'b10: begin_sel = ctrl[CTL_NEW_HW] ? BEGIN_CFG : BEGIN_MIN; // R8
      default: begin_sel = BEGIN_MIN;
    endcase
  end

  // Presence edge detect.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pres_q <= 1'b0;
    end else begin
      pres_q <= i_presence;
    end
  end

  // Phase machine with the wait timer and telegram emission.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      phase <= ST_IDLE;
      wait_cnt <= 9'h000; // R17
      out_level <= OUT_OFF_VALUE;
      o_tg_valid <= 1'b0;
      o_tg_kind <= TG_SWITCH;
      o_tg_data <= 8'h00;
      o_startup_req <= 1'b0;
      pres_seen <= 1'b0;
    end else begin
      o_tg_valid <= 1'b0;
      o_startup_req <= 1'b0;
      case (phase)
        ST_IDLE, ST_MAIN, ST_STARTUP, ST_HOLD: begin
          if (ev_sd) begin
            pres_seen <= 1'b0;
            case (begin_sel)
              BEGIN_OFF: begin
                phase <= ST_SD_END; // R2
              end
              BEGIN_CFG: begin
                o_tg_valid <= 1'b1; // R2
                o_tg_kind <= TG_VALUE;
                o_tg_data <= 8'((16'(cfg_pct < PCT_MIN ? PCT_MIN :
                  cfg_pct > PCT_MAX ? PCT_MAX : cfg_pct) * 16'd255) /
                  16'd100);
                wait_cnt <= 9'(WAIT_BASE_S) + 9'(add_wait); // R4
                phase <= ST_SD_WAIT;
              end
              default: begin
                o_tg_valid <= 1'b1; // R3
                o_tg_kind <= ctrl[CTL_MIN_REL] ? TG_DIM : TG_VALUE;
                o_tg_data <= ctrl[CTL_MIN_REL] ? 8'(DIM_DOWN_100) :
                             OUT_MIN_VALUE;
                wait_cnt <= 9'(WAIT_BASE_S) + 9'(add_wait); // R4
                phase <= ST_SD_WAIT;
              end
            endcase
          end else if (phase == ST_HOLD) begin
            // A step-down is taken above; otherwise stay until lux drops below setpoint or a presence event.
            if (i_lux < setpoint || ev_pres) begin
              phase <= ST_MAIN; // R1
            end
          end else if (ev_limit && !ctrl[CTL_LIMIT_EVAL]) begin
            phase <= ST_HOLD; // R1
          end else if (ev_pres || (i_presence && !pres_q &&
                       phase == ST_IDLE)) begin
            o_startup_req <= 1'b1;
            phase <= ST_STARTUP;
          end
        end
        ST_SD_WAIT: begin
          // Ignored presence is only noted, so the timer never stalls.
          if ((ev_pres || (i_presence && !pres_q)) &&
              !ctrl[CTL_PRES_REACT]) begin
            pres_seen <= 1'b1; // R6
          end
          if ((ev_pres || (i_presence && !pres_q)) &&
              ctrl[CTL_PRES_REACT]) begin
            o_startup_req <= 1'b1; // R7
            phase <= ST_STARTUP;
          end else if (wait_cnt == 9'h000) begin
            if (ctrl[CTL_AFTER_KEEP]) begin
              phase <= ST_IDLE; // R5
              if (pres_seen || i_presence) begin
                o_startup_req <= 1'b1; // R6
                phase <= ST_STARTUP;
              end
            end else begin
              phase <= ST_SD_END; // R5
            end
          end else if (tick) begin
            wait_cnt <= wait_cnt - 9'h001; // R17
          end
        end
        ST_SD_END: begin
          o_tg_valid <= 1'b1; // R5
          o_tg_kind <= ctrl[CTL_OFF_REL] ? TG_VALUE : TG_SWITCH;
          o_tg_data <= OUT_OFF_VALUE;
          phase <= ST_IDLE;
          if (pres_seen || i_presence) begin
            o_startup_req <= 1'b1; // R6
            phase <= ST_STARTUP;
          end
        end
        default: phase <= ST_IDLE;
      endcase
      if (o_tg_valid) begin
        out_level <= o_tg_data;
      end
    end
  end

endmodule

// >>> verification/light_ctrl_sva.sv
// Purpose: Port-level assertions for the step-down light controller.
// Assumes: One clock domain, asynchronous active-high reset.
// Notes: Sees only top-level ports; attached by the bind at the foot.
`timescale 1ns/1ps
module light_ctrl_sva
  import light_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Register bus.
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // Telegram and phase outputs.
  input wire logic o_tg_valid,
  input wire logic [1:0] o_tg_kind,
  input wire logic [7:0] o_tg_data,
  input wire logic o_startup_req
);
  // ****************************************
  // Properties on the bus, the telegram port and the startup request.
  // ****************************************
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  ack_follows_req_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
    |=> o_wb_ack) else $error("ack missing after request");
  ack_single_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  ack_has_cause_a: assert property (o_wb_ack |-> $past(i_wb_stb))
    else $error("ack without request");
  unmapped_reads_zero_a: assert property (o_wb_ack && !i_wb_we
    && i_wb_adr >= 8'h1c |-> o_wb_dat == 32'h0000_0000)
    else $error("unmapped read not zero");
  tg_single_pulse_a: assert property (o_tg_valid |=> !o_tg_valid)
    else $error("telegram strobe too long");
  dim_step_down_a: assert property (o_tg_valid && o_tg_kind == TG_DIM
    |-> o_tg_data == DIM_DOWN_100)
    else $error("dimming step is not full down");
  switch_is_off_a: assert property (o_tg_valid && o_tg_kind == TG_SWITCH
    |-> o_tg_data == OUT_OFF_VALUE)
    else $error("switch telegram is not off");
  tg_fields_hold_a: assert property (!o_tg_valid
    |-> $stable(o_tg_kind) && $stable(o_tg_data))
    else $error("telegram fields moved without strobe");
  tg_kind_legal_a: assert property (o_tg_valid |-> o_tg_kind != 2'b11)
    else $error("illegal telegram kind");
  startup_pulse_a: assert property (o_startup_req |=> !o_startup_req)
    else $error("startup request longer than one cycle");

  // Main scenarios seen.
  cover property (o_tg_valid && o_tg_kind == TG_VALUE);
  cover property (o_tg_valid && o_tg_kind == TG_DIM);
  cover property (o_startup_req);
endmodule

bind light_ctrl light_ctrl_sva light_ctrl_sva_inst (.i_clk_sys, .i_rst,
  .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack,
  .o_tg_valid, .o_tg_kind, .o_tg_data, .o_startup_req);

// >>> verification/dimmer_model.sv
// Purpose: Behavioural dimmer actuator on the telegram port.
// Assumes: One telegram per strobe, taken at the rising edge.
// Notes: Keeps a lamp level so a lamp's view of the output is visible.
`timescale 1ns/1ps
module dimmer_model (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Telegrams from the controller.
  input wire logic i_tg_valid,
  input wire logic [1:0] i_tg_kind,
  input wire logic [7:0] i_tg_data,
  // Observed state.
  output logic [7:0] o_count,
  output logic [1:0] o_kind,
  output logic [7:0] o_data,
  output logic [7:0] o_level
);
  // A full step down lands at the lowest level, never at off.
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_count <= 8'h00;
      o_kind <= 2'b00;
      o_data <= 8'h00;
      o_level <= 8'h00;
    end else if (i_tg_valid) begin
      o_count <= o_count + 8'h01;
      o_kind <= i_tg_kind;
      o_data <= i_tg_data;
      if (i_tg_kind == 2'b01) o_level <= i_tg_data;
      else if (i_tg_kind == 2'b10) o_level <= 8'h01;
      else o_level <= (i_tg_data == 8'h00) ? 8'h00 : 8'hff;
    end
  end
endmodule

// >>> verification/tb.sv
// Purpose: Self-checking bench for the step-down light controller.
// Assumes: Shortened seconds tick; a dimmer model on the telegram port.
// Notes: Expected values come from the package constants and the rules.
`timescale 1ns/1ps
module tb;
  import light_ctrl_pkg::*;
  localparam int T = 10;
  localparam int W = 12;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [3:0] i_wb_sel = 4'hf;
  logic [31:0] i_wb_dat = 32'h0000_0000;
  logic [11:0] i_lux = 12'h000;
  logic i_presence = 1'b0;
  logic [31:0] o_wb_dat, q;
  logic o_wb_ack, o_tg_valid, o_startup_req, o_fast_pace;
  logic [1:0] o_tg_kind, lk;
  logic [7:0] o_tg_data, cnt, ld, lv, c0;
  int error_cnt = 0;
  int tests_run = 0;
  int st_cnt = 0;
  int s0 = 0;

  light_ctrl #(.TICK_CYC(T)) light_ctrl_inst (.i_clk_sys, .i_rst,
    .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
    .o_wb_dat, .o_wb_ack, .i_lux, .i_presence, .o_tg_valid, .o_tg_kind,
    .o_tg_data, .o_startup_req, .o_fast_pace);
  dimmer_model dimmer_model_inst (.i_clk_sys, .i_rst,
    .i_tg_valid(o_tg_valid), .i_tg_kind(o_tg_kind), .i_tg_data(o_tg_data),
    .o_count(cnt), .o_kind(lk), .o_data(ld), .o_level(lv));

  // Free-running 40 MHz clock.
  initial begin
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end

  // Counts startup hand-offs, sampled at the edge.
  always @(posedge i_clk_sys) begin
    if (o_startup_req === 1'b1) st_cnt++;
  end

  // ****************************************
  // Shared tasks.
  // ****************************************
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask

  // Classic single cycle; request held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= d;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_wb_ack !== 1'b1 && n < 20);
    q = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
    @(posedge i_clk_sys);
    if (n >= 20) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  // A missing telegram ends the run, since later steps would be void.
  task automatic await_tg(input logic [7:0] c, input int b);
    int n;
    n = 0;
    while (cnt !== c && n < b) begin
      @(posedge i_clk_sys);
      n++;
    end
    if (cnt !== c) begin
      error_cnt++;
      tally_and_finish();
    end
  endtask

  task automatic begin_sd(input logic [31:0] c);
    wb(1'b1, REG_CTRL, CTRL_RESET | c);
    wb(1'b1, REG_EVENT, 32'h0000_0001);
    tick(2);
    c0 = cnt;
    s0 = st_cnt;
    wb(1'b1, REG_EVENT, 32'h0000_0002);
  endtask

  // First telegram at once, second only after the whole wait.
  task automatic sd(input logic [31:0] c, input logic [9:0] e1,
                    input logic two, input logic [9:0] e2);
    begin_sd(c);
    await_tg(c0 + 8'h01, 10);
    chk(32'({lk, ld}), 32'(e1));
    tick((W - 1) * T - 8);
    chk(32'(cnt), 32'(c0 + 8'h01));
    if (two) begin
      await_tg(c0 + 8'h02, 2 * T + 20);
      chk(32'({lk, ld}), 32'(e2));
    end else begin
      tick(2 * T + 20);
      chk(32'(cnt), 32'(c0 + 8'h01));
    end
  endtask

  // ****************************************
  // Test sequence.
  // ****************************************
  initial begin
    tick(5);
    i_rst <= 1'b0;
    tick(1);
    wb(1'b0, REG_CTRL, 32'h0000_0000);
    chk(q, CTRL_RESET);
    wb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(q & 32'h001f_ffff, 32'h0000_0000);
    wb(1'b0, 8'h1c, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    wb(1'b1, REG_STEP, 32'h0002_0502);
    wb(1'b1, REG_SETPOINT, 32'h0064_012c);
    $display("Test reset done");
    sd(32'h0000_0004, {TG_VALUE, OUT_MIN_VALUE}, 1'b1,
       {TG_SWITCH, OUT_OFF_VALUE});
    sd(32'h0000_0054, {TG_DIM, 8'(DIM_DOWN_100)}, 1'b1,
       {TG_VALUE, OUT_OFF_VALUE});
    sd(32'h0000_0108, {TG_VALUE, 8'hff}, 1'b1,
       {TG_SWITCH, OUT_OFF_VALUE});
    sd(32'h0000_0008, {TG_VALUE, OUT_MIN_VALUE}, 1'b1,
       {TG_SWITCH, OUT_OFF_VALUE});
    sd(32'h0000_0024, {TG_VALUE, OUT_MIN_VALUE}, 1'b0, 10'h000);
    sd(32'h0000_0000, {TG_SWITCH, OUT_OFF_VALUE}, 1'b0, 10'h000);
    $display("Test step-down done");
    begin_sd(32'h0000_0084);
    tick(20);
    i_presence <= 1'b1;
    wb(1'b1, REG_EVENT, 32'h0000_0001);
    tick(3);
    chk(32'(st_cnt), 32'(s0 + 1));
    tick(W * T + 2 * T);
    chk(32'(cnt), 32'(c0 + 8'h01));
    i_presence <= 1'b0;
    begin_sd(32'h0000_0004);
    tick(20);
    i_presence <= 1'b1;
    wb(1'b1, REG_EVENT, 32'h0000_0001);
    tick(5);
    chk(32'(st_cnt), 32'(s0));
    await_tg(c0 + 8'h02, W * T + 20);
    tick(5);
    chk(32'(st_cnt), 32'(s0 + 1));
    i_presence <= 1'b0;
    $display("Test presence done");
    wb(1'b1, REG_CTRL, CTRL_RESET);
    i_lux <= 12'h190;
    c0 = cnt;
    wb(1'b1, REG_EVENT, 32'h0000_0004);
    tick(20);
    chk(32'(cnt), 32'(c0));
    wb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(q & 32'h0000_0007, 32'(ST_HOLD));
    i_lux <= 12'h000;
    tick(2);
    wb(1'b0, REG_STATUS, 32'h0000_0000);
    chk(q & 32'h0000_0007, 32'(ST_MAIN));
    $display("Test lower limit done");
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, REG_SETPOINT, {20'h0_0000, 12'(i * 200 + 10)});
      wb(1'b0, REG_SETPOINT, 32'h0000_0000);
      chk(q & 32'h0000_0fff, {20'h0_0000,
          (i == 0) ? STD_SP_MIN : 12'(i * 200 / 50 * 50)});
    end
    for (int sp = 300; sp <= 500; sp += 200) begin
      wb(1'b1, REG_SETPOINT, 32'(sp));
      wb(1'b0, REG_RANGE, 32'h0000_0000);
      chk(q, 32'(sp * 6 / 5));
      wb(1'b0, REG_DERIVED, 32'h0000_0000);
      chk((q >> 16) & 32'h0000_1fff, 32'(sp + sp * (int'(CTRL_RESET[23:16])
          + int'(CTRL_RESET[31:24])) / 100));
    end
    $display("Test standard range done");
    wb(1'b1, REG_CTRL, CTRL_RESET | 32'h0000_0001);
    wb(1'b1, REG_RANGE, 32'h09c4_0005);
    wb(1'b0, REG_RANGE, 32'h0000_0000);
    chk(q & 32'h0fff_0fff, {4'h0, LUX_MAX, 4'h0, USER_MAX_MIN});
    wb(1'b1, REG_SETPOINT, 32'h0000_09c4);
    wb(1'b0, REG_SETPOINT, 32'h0000_0000);
    chk(q & 32'h0000_0fff, {20'h0_0000, LUX_MAX});
    wb(1'b1, REG_SETPOINT, 32'h0000_03e8);
    wb(1'b1, REG_RANGE, 32'h00c8_07d0);
    i_lux <= 12'h064;
    tick(5);
    chk(32'(o_fast_pace), 32'h0000_0001);
    i_lux <= 12'h12c;
    tick(5);
    chk(32'(o_fast_pace), 32'h0000_0000);
    $display("Test user range done");
    tally_and_finish();
  end
endmodule
